// ===== include/amon_pkg.sv
// Package for the alarm monitor: register map, field layout, reset values and shared types
package amon_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00; // Sticky alarm status, read clears
    localparam logic [7:0] ADDR_ENABLE = 8'h04; // Per-source alert enable
    localparam logic [7:0] ADDR_CONFIG = 8'h08; // Latch disable and count selects
    localparam logic [7:0] ADDR_SWRST = 8'h0c; // Any write clears alarms
    localparam logic [7:0] ADDR_HYS_BASE = 8'h10; // Seven hysteresis words, 4 bytes apart
    localparam logic [7:0] ADDR_HI_BASE = 8'h30; // Seven high thresholds
    localparam logic [7:0] ADDR_LO_BASE = 8'h50; // Seven low thresholds
    localparam logic [7:0] ADDR_IRQ_ST = 8'h70; // Event status, write one to clear
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h74; // Event mask

    // ------------------------------------------------------------
    // Sizes and field positions
    // ------------------------------------------------------------
    localparam int NUM_CH = 7; // Four analog, three temperature channels
    localparam int NUM_ANALOG = 4; // Channels 0..3 are analog
    localparam int NUM_SRC = 11; // 4 analog, 3x2 temperature, die overheat
    localparam int CFG_LATCH_DIS_BIT = 0; // latch_disable position
    localparam int CFG_ACNT_LSB = 4; // analog_consec_count_sel [6:4]
    localparam int CFG_TCNT_LSB = 8; // temp_consec_count_sel [9:8]
    localparam int SRC_DIE_BIT = 10; // die_overheat_flag status position

    // ------------------------------------------------------------
    // Reset values and fixed figures
    // ------------------------------------------------------------
    localparam logic [2:0] ACNT_RESET = 3'h3; // Analog N = 16
    localparam logic [1:0] TCNT_RESET = 2'h2; // Temperature N = 4
    localparam logic [11:0] HI_RESET = 12'hfff; // Window wide open for analog channels only
    localparam logic [11:0] LO_RESET = 12'h000;
    localparam logic [6:0] HYS_RESET = 7'h08;
    localparam logic [NUM_SRC-1:0] ENABLE_RESET = 11'h000;
    localparam logic [11:0] DIE_HYS = 12'h008; // Fixed 8 degree hysteresis

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic latch_disable;
        logic [2:0] analog_consec_count_sel;
        logic [1:0] temp_consec_count_sel;
    } amon_cfg_t;

    typedef struct packed {
        logic valid;        // One-cycle conversion strobe
        logic [2:0] chan;   // Channel index 0..6
        logic [11:0] value; // Result, two's complement for temperatures
    } amon_conv_t;

    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,   // In window
        CH_COUNT = 2'b01,  // Counting out-of-range samples
        CH_ALARM = 2'b11   // Condition raised, waiting for hysteresis
    } amon_chst_t;

endpackage : amon_pkg

// ===== core/amon_chan.sv
// One monitored channel: consecutive-sample filter and hysteresis release
`timescale 1ns/1ns
module amon_chan (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Conversion
    input wire logic sample,
    input wire logic is_temp,
    input wire logic [11:0] value,
    input wire logic [11:0] hi_lim,
    input wire logic [11:0] lo_lim,
    input wire logic [11:0] hys,
    input wire logic [8:0] need_n,
    // Conditions
    output logic cond_hi,
    output logic cond_lo
);

    // Signed compare for temperatures, unsigned for analog
    function automatic logic less(input logic [11:0] a, input logic [11:0] b, input logic sgn);
        less = sgn ? ($signed(a) < $signed(b)) : (a < b);
    endfunction : less

    logic [8:0] run_hi; // Consecutive samples above window
    logic [8:0] run_lo; // Consecutive samples below window
    logic [12:0] rel_hi; // Release point below high limit
    logic [12:0] rel_lo; // Release point above low limit
    logic above, below, back_hi, back_lo;

    // Widen by one bit so hysteresis never wraps around
    assign rel_hi = {is_temp & hi_lim[11], hi_lim} - {1'b0, hys};
    assign rel_lo = {is_temp & lo_lim[11], lo_lim} + {1'b0, hys};
    assign above = less(hi_lim, value, is_temp);
    assign below = less(value, lo_lim, is_temp);
    // Hysteresis release points
    // Signed on both sides, so a high limit below the hysteresis never releases at once
    assign back_hi = $signed({is_temp & value[11], value}) <= $signed(rel_hi);
    assign back_lo = is_temp ? ($signed({value[11], value}) >= $signed(rel_lo)) : ({1'b0, value} >= rel_lo);

    // High side filter and condition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_hi <= 9'h000;
            cond_hi <= 1'b0;
        end else if (ce && sample) begin
            run_hi <= above ? ((run_hi == need_n) ? run_hi : run_hi + 9'h001) : 9'h000;
            // Raise after N in a row
            if (above && (run_hi + 9'h001 >= need_n)) begin
                cond_hi <= 1'b1;
            end else if (back_hi) begin
                cond_hi <= 1'b0;
            end
        end
    end

    // Low side filter and condition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_lo <= 9'h000;
            cond_lo <= 1'b0;
        end else if (ce && sample) begin
            run_lo <= below ? ((run_lo == need_n) ? run_lo : run_lo + 9'h001) : 9'h000;
            // Raise after N in a row
            if (below && (run_lo + 9'h001 >= need_n)) begin
                cond_lo <= 1'b1;
            end else if (back_lo) begin
                cond_lo <= 1'b0;
            end
        end
    end

    // Single sample never raises when N above one
    single_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && sample && above && run_hi == 9'h000 && need_n > 9'h001 && !cond_hi) |=> !cond_hi)
        else $error("high condition raised before N samples");

endmodule : amon_chan

// ===== core/amon_top.sv
// Alarm monitor top: APB registers, channel filters, status latching and open-drain alarm pin
//
// Operation
// - Alarm pin pulls low, else released
// - Enabled sources alone drive the pin
// - Masked sources still set status
// - Latched bit needs resolution plus read
// - Status read clears; live conditions return
// - Resets clear all status bits
// - Latch disabled: status follows condition
// - Release only past hysteresis from limit
// - Per-channel programmable hysteresis ranges
// - Die overheat uses fixed 8 degrees
// - Alarm after N consecutive bad samples
// - Analog count select maps to N
// - Temperature count select maps to N
// - Global flag ORs enabled alarms
// - Thresholds form window per channel
// - Temperatures have high and low bits
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module amon_top (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Conversion results and die sensor
    input wire amon_pkg::amon_conv_t conv,
    input wire logic die_temp_valid,
    input wire logic [11:0] die_temp,
    input wire logic [11:0] die_limit,
    // Alarm pin and flags
    output logic alarm_o,
    output logic alarm_oen,
    output logic global_flag,
    output logic irq
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [amon_pkg::NUM_SRC-1:0] status; // Alarm status bits
    logic [amon_pkg::NUM_SRC-1:0] source_alert_enable; // Per-source pin enable
    amon_pkg::amon_cfg_t cfg; // Latch disable and count selects
    logic [6:0] hys_r [amon_pkg::NUM_CH]; // Hysteresis per channel
    logic [11:0] hi_r [amon_pkg::NUM_CH]; // High thresholds
    logic [11:0] lo_r [amon_pkg::NUM_CH]; // Low thresholds
    logic [1:0] irq_st; // bit0 new alarm, bit1 global flag rose
    logic [1:0] irq_mask;
    logic sw_reset; // One-cycle soft reset of alarms
    logic die_overheat_flag; // Die condition with fixed hysteresis

    logic wr_en, rd_en;
    logic [amon_pkg::NUM_SRC-1:0] cond; // Live conditions
    logic [amon_pkg::NUM_CH-1:0] c_hi, c_lo;
    logic [8:0] n_analog, n_temp;
    logic prev_flag;

    // ------------------------------------------------------------
    // Count select decode
    // ------------------------------------------------------------
    // Analog N table
    function automatic logic [8:0] analog_n(input logic [2:0] s);
        analog_n = (s == 3'h0) ? 9'h001 : (9'h002 << s);
    endfunction : analog_n

    function automatic logic [8:0] temp_n(input logic [1:0] s);
        temp_n = 9'h001 << s;
    endfunction : temp_n

    // Word index inside a 7-entry array block
    function automatic logic [2:0] word_idx(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] d;
        d = a - base;
        word_idx = d[4:2];
    endfunction : word_idx

    assign n_analog = analog_n(cfg.analog_consec_count_sel);
    assign n_temp = temp_n(cfg.temp_consec_count_sel);

    // ------------------------------------------------------------
    // APB access
    // ------------------------------------------------------------
    // Zero wait states; every address answers without error
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en = psel & penable & pwrite & ce;
    assign rd_en = psel & penable & ~pwrite & ce;

    // Does address fall inside a 7-word array block
    function automatic logic in_blk(input logic [7:0] a, input logic [7:0] base);
        in_blk = (a >= base) && (a < base + 8'h1c) && (a[1:0] == 2'b00);
    endfunction : in_blk

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source_alert_enable <= amon_pkg::ENABLE_RESET;
            cfg <= '{1'b0, amon_pkg::ACNT_RESET, amon_pkg::TCNT_RESET};
            irq_mask <= 2'h0;
            sw_reset <= 1'b0;
        end else if (ce) begin
            sw_reset <= wr_en && paddr == amon_pkg::ADDR_SWRST;
            if (wr_en && paddr == amon_pkg::ADDR_ENABLE) begin
                source_alert_enable <= pwdata[amon_pkg::NUM_SRC-1:0];
            end
            if (wr_en && paddr == amon_pkg::ADDR_CONFIG) begin
                cfg.latch_disable <= pwdata[amon_pkg::CFG_LATCH_DIS_BIT];
                cfg.analog_consec_count_sel <= pwdata[amon_pkg::CFG_ACNT_LSB +: 3];
                cfg.temp_consec_count_sel <= pwdata[amon_pkg::CFG_TCNT_LSB +: 2];
            end
            if (wr_en && paddr == amon_pkg::ADDR_IRQ_MASK) begin
                irq_mask <= pwdata[1:0];
            end
        end
    end

    // Threshold and hysteresis arrays
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < amon_pkg::NUM_CH; i++) begin
                hys_r[i] <= amon_pkg::HYS_RESET;
                hi_r[i] <= amon_pkg::HI_RESET;
                lo_r[i] <= amon_pkg::LO_RESET;
            end
        end else if (wr_en) begin
            if (in_blk(paddr, amon_pkg::ADDR_HYS_BASE)) begin
                hys_r[word_idx(paddr, amon_pkg::ADDR_HYS_BASE)] <=
                    (word_idx(paddr, amon_pkg::ADDR_HYS_BASE) < 3'(amon_pkg::NUM_ANALOG)) ?
                    pwdata[6:0] : {2'b00, pwdata[4:0]};
            end
            if (in_blk(paddr, amon_pkg::ADDR_HI_BASE)) begin
                hi_r[word_idx(paddr, amon_pkg::ADDR_HI_BASE)] <= pwdata[11:0];
            end
            if (in_blk(paddr, amon_pkg::ADDR_LO_BASE)) begin
                lo_r[word_idx(paddr, amon_pkg::ADDR_LO_BASE)] <= pwdata[11:0];
            end
        end
    end

    // Read mux, registered so data comes from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (paddr == amon_pkg::ADDR_STATUS) prdata <= 32'(status);
            if (paddr == amon_pkg::ADDR_ENABLE) prdata <= 32'(source_alert_enable);
            if (paddr == amon_pkg::ADDR_CONFIG) begin
                prdata <= 32'({cfg.temp_consec_count_sel, 1'b0, cfg.analog_consec_count_sel, 3'b000,
                    cfg.latch_disable});
            end
            if (paddr == amon_pkg::ADDR_IRQ_ST) prdata <= 32'(irq_st);
            if (paddr == amon_pkg::ADDR_IRQ_MASK) prdata <= 32'(irq_mask);
            if (in_blk(paddr, amon_pkg::ADDR_HYS_BASE)) begin
                prdata <= 32'(hys_r[word_idx(paddr, amon_pkg::ADDR_HYS_BASE)]);
            end
            if (in_blk(paddr, amon_pkg::ADDR_HI_BASE)) begin
                prdata <= 32'(hi_r[word_idx(paddr, amon_pkg::ADDR_HI_BASE)]);
            end
            if (in_blk(paddr, amon_pkg::ADDR_LO_BASE)) begin
                prdata <= 32'(lo_r[word_idx(paddr, amon_pkg::ADDR_LO_BASE)]);
            end
        end
    end

    // ------------------------------------------------------------
    // Channel filters
    // ------------------------------------------------------------
    for (genvar g = 0; g < amon_pkg::NUM_CH; g++) begin : g_ch
        amon_chan u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .sample(conv.valid && conv.chan == 3'(g)),
            .is_temp(g >= amon_pkg::NUM_ANALOG),
            .value(conv.value),
            .hi_lim(hi_r[g]),
            .lo_lim(lo_r[g]),
            .hys({5'h00, hys_r[g]}),
            .need_n((g >= amon_pkg::NUM_ANALOG) ? n_temp : n_analog),
            .cond_hi(c_hi[g]),
            .cond_lo(c_lo[g])
        );
    end

    // Die flag clears 8 degrees below limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            die_overheat_flag <= 1'b0;
        end else if (ce && die_temp_valid) begin
            if ($signed(die_temp) > $signed(die_limit)) begin
                die_overheat_flag <= 1'b1;
            end else if ($signed(die_temp) <= $signed(die_limit - amon_pkg::DIE_HYS)) begin
                die_overheat_flag <= 1'b0;
            end
        end
    end

    // Analog window bits, then temperature high/low pairs
    assign cond = {die_overheat_flag, c_lo[6], c_hi[6], c_lo[5], c_hi[5], c_lo[4], c_hi[4],
        c_hi[3] | c_lo[3], c_hi[2] | c_lo[2], c_hi[1] | c_lo[1], c_hi[0] | c_lo[0]};

    // ------------------------------------------------------------
    // Status latching
    // ------------------------------------------------------------
    // A live condition re-sets the bit in the same cycle as a read, so it never drops out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
        end else if (ce) begin
            if (sw_reset) begin
                status <= '0;
            end else if (cfg.latch_disable) begin
                status <= cond;
            end else if (rd_en && paddr == amon_pkg::ADDR_STATUS) begin
                status <= cond;
            end else begin
                status <= status | cond;
            end
        end
    end

    // Only enabled bits reach the flag
    assign global_flag = |(status & source_alert_enable);

    // Open-drain: drive low with enable low
    assign alarm_o = 1'b0;
    assign alarm_oen = ~global_flag;

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st <= 2'h0;
            prev_flag <= 1'b0;
        end else if (ce) begin
            prev_flag <= global_flag;
            // Set beats a clear in the same cycle
            irq_st <= (irq_st & ~((wr_en && paddr == amon_pkg::ADDR_IRQ_ST) ? pwdata[1:0] : 2'h0))
                | {global_flag & ~prev_flag, |(cond & ~status)};
        end
    end

    assign irq = |(irq_st & irq_mask);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence status_read_s;
        ce && rd_en && paddr == amon_pkg::ADDR_STATUS && !sw_reset;
    endsequence

    pin_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        alarm_oen == !global_flag && alarm_o == 1'b0)
        else $error("alarm pin enable disagrees with flag");

    masked_src_a: assert property (@(posedge pclk) disable iff (!presetn)
        (status & source_alert_enable) == '0 |-> alarm_oen)
        else $error("pin pulled by masked source");

    masked_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !sw_reset && !source_alert_enable[0] && cond[0]) |=> status[0])
        else $error("condition failed to set status");

    sticky_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !cfg.latch_disable && status[0] && !sw_reset && !(rd_en && paddr == amon_pkg::ADDR_STATUS))
        |=> status[0])
        else $error("latched bit dropped without read");

    read_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        status_read_s |=> status == $past(cond))
        else $error("status read did not clear resolved bits");

    soft_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && sw_reset) |=> status == '0)
        else $error("software reset left status set");

    transparent_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && cfg.latch_disable && !sw_reset) |=> status == $past(cond))
        else $error("transparent status not following condition");

    count_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg.analog_consec_count_sel == 3'h3 |-> n_analog == 9'h010) and
        (cfg.temp_consec_count_sel == 2'h2 |-> n_temp == 9'h004))
        else $error("count select decode wrong");

endmodule : amon_top

// ===== sim/amon_host.sv
// Host model: APB master, alarm pin pull-up and alarm service
`timescale 1ns/1ns
module amon_host (
    // Clock
    input wire logic pclk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // Open-drain alarm pin
    input wire logic alarm_o,
    input wire logic alarm_oen,
    output logic alarm_pin
);
    // ----------------------------------------
    // Pin and bus idle levels
    // ----------------------------------------
    // pull-up when released
    assign alarm_pin = alarm_oen ? 1'b1 : alarm_o;

    // Bus idle from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // One transfer; never assumes a latency, waits on pready
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic serve(output logic [31:0] q);
        q = 32'h0;
        if (alarm_pin === 1'b0) xfer(1'b0, amon_pkg::ADDR_STATUS, 32'h0, q);
    endtask : serve
endmodule : amon_host

// ===== sim/amon_top_tb_top.sv
// Testbench for the alarm monitor top
`timescale 1ns/1ns
module amon_top_tb_top;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic pclk, presetn, ce, die_temp_valid;
    logic [11:0] die_temp;
    amon_pkg::amon_conv_t conv;
    // Bus and outputs
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic alarm_o, alarm_oen, global_flag, irq, pin;
    int n_checks = 0;
    int fail_count = 0;
    int cyc = 0;

    // Die limit tied: 150 degrees
    amon_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv(conv), .die_temp_valid(die_temp_valid), .die_temp(die_temp),
        .die_limit(12'h096), .alarm_o(alarm_o), .alarm_oen(alarm_oen), .global_flag(global_flag),
        .irq(irq));

    amon_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .alarm_o(alarm_o),
        .alarm_oen(alarm_oen), .alarm_pin(pin));

    // Clock and hang guard
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // Flags {irq, pin, global_flag}, sampled settled
    task automatic chkf(input logic [2:0] e);
        @(negedge pclk);
        chk({29'h0, irq, pin, global_flag}, {29'h0, e});
    endtask : chkf

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, q);
        chk(q, e);
        // No access ever answers with an error
        chk({31'h0, pslverr}, 32'h0);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask : wr

    // Send n conversions, then let status settle
    task automatic smp(input logic [2:0] c, input logic [11:0] v, input int n);
        repeat (n) begin
            @(posedge pclk);
            conv <= '{valid: 1'b1, chan: c, value: v};
            @(posedge pclk);
            conv.valid <= 1'b0;
        end
        repeat (3) @(posedge pclk);
    endtask : smp

    task automatic die(input logic [11:0] v);
        @(posedge pclk);
        die_temp <= v;
        die_temp_valid <= 1'b1;
        @(posedge pclk);
        die_temp_valid <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : die

    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        ce = 1'b1;
        conv = '0;
        die_temp_valid = 1'b0;
        die_temp = 12'h000;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chkf(3'b010);
        rd(amon_pkg::ADDR_STATUS, 32'h0);
        rd(amon_pkg::ADDR_CONFIG, 32'h230);
        rd(amon_pkg::ADDR_HI_BASE, 32'hfff);
        rd(amon_pkg::ADDR_HYS_BASE, 32'h8);
        rd(8'hfc, 32'h0);
        $display("test reset done");
        // Window 0x10..0x100, analog N of 4, latched
        wr(amon_pkg::ADDR_HI_BASE, 32'h100);
        wr(amon_pkg::ADDR_LO_BASE, 32'h010);
        wr(amon_pkg::ADDR_CONFIG, 32'h210);
        smp(3'd0, 12'h200, 3);
        smp(3'd0, 12'h080, 1);
        smp(3'd0, 12'h005, 3);
        rd(amon_pkg::ADDR_STATUS, 32'h0);
        smp(3'd0, 12'h005, 1);
        rd(amon_pkg::ADDR_STATUS, 32'h1);
        chkf(3'b010);
        wr(amon_pkg::ADDR_ENABLE, 32'h1);
        chkf(3'b001);
        host.serve(q);
        chk(q, 32'h1);
        // Inside window but within hysteresis of the low limit
        smp(3'd0, 12'h014, 1);
        rd(amon_pkg::ADDR_STATUS, 32'h1);
        smp(3'd0, 12'h018, 1);
        rd(amon_pkg::ADDR_STATUS, 32'h1);
        rd(amon_pkg::ADDR_STATUS, 32'h0);
        chkf(3'b010);
        // Resolved but latched, then software reset
        smp(3'd0, 12'h300, 4);
        smp(3'd0, 12'h080, 1);
        chkf(3'b001);
        wr(amon_pkg::ADDR_SWRST, 32'h1);
        repeat (2) @(posedge pclk);
        rd(amon_pkg::ADDR_STATUS, 32'h0);
        $display("test latch done");
        // Every analog count select, transparent status
        for (int s = 0; s < 8; s++) begin
            wr(amon_pkg::ADDR_CONFIG, 32'h201 | (s << 4));
            smp(3'd0, 12'h300, (s == 0) ? 0 : (1 << (s + 1)) - 1);
            chkf(3'b010);
            smp(3'd0, 12'h300, 1);
            chkf(3'b001);
            smp(3'd0, 12'h080, 1);
            chkf(3'b010);
        end
        $display("test analog count done");
        // Remote channel: limits 0x50 and -40, hysteresis 100 cut to 4
        wr(amon_pkg::ADDR_ENABLE, 32'h31);
        wr(amon_pkg::ADDR_HI_BASE + 8'h10, 32'h050);
        wr(amon_pkg::ADDR_LO_BASE + 8'h10, 32'hfd8);
        wr(amon_pkg::ADDR_HYS_BASE + 8'h10, 32'h64);
        rd(amon_pkg::ADDR_HYS_BASE + 8'h10, 32'h4);
        for (int t = 0; t < 4; t++) begin
            wr(amon_pkg::ADDR_CONFIG, 32'h001 | (t << 8));
            smp(3'd4, 12'h060, (1 << t) - 1);
            chkf(3'b010);
            smp(3'd4, 12'h060, 1);
            rd(amon_pkg::ADDR_STATUS, 32'h10);
            smp(3'd4, 12'h000, 1);
            chkf(3'b010);
        end
        smp(3'd4, 12'hfc0, 8);
        rd(amon_pkg::ADDR_STATUS, 32'h20);
        smp(3'd4, 12'h000, 1);
        $display("test temperature done");
        // Die overheat with fixed release point at 142
        wr(amon_pkg::ADDR_CONFIG, 32'h001);
        wr(amon_pkg::ADDR_ENABLE, 32'h400);
        die(12'h0a0);
        chkf(3'b001);
        die(12'h090);
        chkf(3'b001);
        die(12'h08e);
        chkf(3'b010);
        // Event interrupt raised, cleared, then masked
        wr(amon_pkg::ADDR_IRQ_MASK, 32'h3);
        wr(amon_pkg::ADDR_IRQ_ST, 32'h3);
        chkf(3'b010);
        die(12'h0a0);
        chkf(3'b101);
        rd(amon_pkg::ADDR_IRQ_ST, 32'h3);
        wr(amon_pkg::ADDR_IRQ_ST, 32'h3);
        chkf(3'b001);
        wr(amon_pkg::ADDR_IRQ_MASK, 32'h0);
        die(12'h08e);
        die(12'h0a0);
        chkf(3'b001);
        rd(amon_pkg::ADDR_IRQ_ST, 32'h3);
        $display("test die and irq done");
        // A write while the clock enable is low must not land
        ce <= 1'b0;
        wr(amon_pkg::ADDR_ENABLE, 32'h0);
        ce <= 1'b1;
        chkf(3'b001);
        // Hardware reset in mid-run drops the live alarm
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chkf(3'b010);
        rd(amon_pkg::ADDR_STATUS, 32'h0);
        $display("test enable and reset done");
        end_sim();
    end
endmodule : amon_top_tb_top
